// File: design/baud_tick.sv
// fractional baud generator giving eight subticks per bit
module baud_tick #(
  parameter int ACC_WIDTH = 25
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] mantissa,
  input wire logic [4:0] exponent,
  output logic tick
);

  localparam int SUM_WIDTH = ACC_WIDTH + 16;

  logic [ACC_WIDTH-1:0] acc;
  logic [SUM_WIDTH-1:0] increment;
  logic [SUM_WIDTH-1:0] sum;

  // ==========================================================================
  // subtick rate = mclk * (256 + m) * 2^e / 2^25, bit rate is one eighth
  // of it; an increment past the accumulator range ticks every cycle
  assign increment = SUM_WIDTH'({1'b1, mantissa}) << exponent;
  assign sum = SUM_WIDTH'(acc) + increment;

  // phase accumulator, carry out is the tick
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      acc <= sum[ACC_WIDTH-1:0];
      tick <= |sum[SUM_WIDTH-1:ACC_WIDTH];
    end
  end

endmodule // baud_tick

// File: design/serial_unit_pkg.sv
// shared constants, types and register map of the dual-mode serial unit
package serial_unit_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_DATA_BUFFER = 8'hC1;
  localparam logic [7:0] IDX_BAUD_MANTISSA = 8'hC2;
  localparam logic [7:0] IDX_FRAME_CONFIG = 8'hC4;
  localparam logic [7:0] IDX_BAUD_EXPONENT = 8'hC5;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hE1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hE2;
  localparam logic [7:0] IDX_CONTROL_STATUS = 8'hF8;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // ==========================================================================
  // control/status field positions
  localparam int CS_MODE = 7;
  localparam int CS_RX_ENABLE = 6;
  localparam int CS_SLAVE = 5;
  localparam int CS_FRAMING = 4;
  localparam int CS_PARITY = 3;
  localparam int CS_RX_BYTE = 2;
  localparam int CS_TX_BYTE = 1;
  localparam int CS_ACTIVE = 0;

  // frame configuration field positions
  localparam int FRM_PARITY_EN = 0;
  localparam int FRM_PARITY_ODD = 1;
  localparam int FRM_TWO_STOP = 2;

  // interrupt status/enable/clear layout
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_FRAMING = 2;
  localparam int IRQ_PARITY = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_DATA_BUFFER = 8'h00;
  localparam logic [7:0] RST_BAUD_MANTISSA = 8'h00;
  localparam logic [4:0] RST_BAUD_EXPONENT = 5'h00;
  localparam logic [2:0] RST_FRAME_CONFIG = 3'h0;
  localparam logic [IRQ_WIDTH-1:0] RST_IRQ = 4'h0;

  // ==========================================================================
  // timing: eight subticks per bit, rx samples at subtick four
  localparam int BAUD_ACC_WIDTH = 25;
  localparam logic [2:0] SUB_SAMPLE = 3'h4;
  localparam logic [2:0] SUB_LAST = 3'h7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================================
  // engine states, gray coded along start-data-parity-stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP1 = 3'h6,
    ST_STOP2 = 3'h7,
    ST_SPI = 3'h5
  } engine_state_type;

  // avalon request group, address is a word index
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [7:0] writedata;
  } bus_request_type;

  // spi pins seen from the unit
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_b;
  } spi_in_type;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } spi_out_type;

endpackage

// File: design/usart_data_baud_status_regs.sv
// dual-mode serial unit: uart or spi, with avalon register access
//
// The Avalon-MM register port was chosen for this implementation.
module usart_data_baud_status_regs #(
  parameter int BAUD_ACC_WIDTH = serial_unit_pkg::BAUD_ACC_WIDTH
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire serial_unit_pkg::bus_request_type bus_req,
  output logic [7:0] readdata,
  output logic waitrequest,
  output logic irq,
  output logic txd,
  input wire logic rxd,
  input wire serial_unit_pkg::spi_in_type spi_in,
  output serial_unit_pkg::spi_out_type spi_out
);
  import serial_unit_pkg::*;

  // ==========================================================================
  // declarations
  logic [4:0] sync_1;
  logic [4:0] sync_2;
  logic rxd_s;
  spi_in_type spi_s;
  logic sck_prev;
  logic tick;

  logic [7:0] tx_buffer;
  logic [7:0] rx_buffer;
  logic [7:0] baud_mantissa;
  logic [4:0] baud_exponent;
  logic [2:0] frame_config;
  logic mode_uart;
  logic rx_enable;
  logic spi_slave;
  logic framing_error_flag;
  logic parity_error;
  logic rx_byte;
  logic tx_byte;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_enable;
  logic tx_pending;

  engine_state_type tx_state;
  engine_state_type next_tx_state;
  logic [2:0] tx_sub;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic tx_parity;
  logic spi_sample;

  engine_state_type rx_state;
  engine_state_type next_rx_state;
  logic [2:0] rx_sub;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_parity;

  // ==========================================================================
  // next state of a frame, shared by both engines
  function automatic engine_state_type frame_next(input engine_state_type state,
                                                  input logic [2:0] bit_index,
                                                  input logic [2:0] cfg);
    engine_state_type result;
    result = ST_IDLE;
    case (state)
      ST_START: result = ST_DATA;
      ST_DATA: begin
        if (bit_index != LAST_BIT) result = ST_DATA;
        else if (cfg[FRM_PARITY_EN]) result = ST_PARITY;
        else result = ST_STOP1;
      end
      ST_PARITY: result = ST_STOP1;
      ST_STOP1: result = cfg[FRM_TWO_STOP] ? ST_STOP2 : ST_IDLE;
      ST_SPI: result = (bit_index == LAST_BIT) ? ST_IDLE : ST_SPI;
      default: result = ST_IDLE;
    endcase
    return result;
  endfunction

  // ==========================================================================
  // pin synchronisers; only the second stage is read by logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // idle levels: rxd and select high, sck low, so no false edge follows reset
      sync_1 <= 5'h17;
      sync_2 <= 5'h17;
      sck_prev <= 1'b0;
    end else if (ce) begin
      sync_1 <= {rxd, spi_in};
      sync_2 <= sync_1;
      sck_prev <= spi_s.sck;
    end
  end

  assign rxd_s = sync_2[4];
  assign spi_s = spi_in_type'(sync_2[3:0]);

  baud_tick #(
    .ACC_WIDTH(BAUD_ACC_WIDTH)
  ) u_baud (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .mantissa(baud_mantissa),
    .exponent(baud_exponent),
    .tick(tick)
  );

  // ==========================================================================
  // avalon slave decode: one wait cycle, then the request is accepted
  wire bus_active = bus_req.read | bus_req.write;
  wire accept = bus_active & ~waitrequest;
  wire wr = accept & bus_req.write;
  wire [7:0] wd = bus_req.writedata;
  wire [7:0] addr = bus_req.address;
  wire wr_data = wr & (addr == IDX_DATA_BUFFER);
  wire wr_mantissa = wr & (addr == IDX_BAUD_MANTISSA);
  wire wr_exponent = wr & (addr == IDX_BAUD_EXPONENT);
  wire wr_frame = wr & (addr == IDX_FRAME_CONFIG);
  wire wr_cs = wr & (addr == IDX_CONTROL_STATUS);
  wire wr_irq_clear = wr & (addr == IDX_IRQ_CLEAR);
  wire wr_irq_enable = wr & (addr == IDX_IRQ_ENABLE);

  // busy covers the engines only, a queued byte alone is not activity
  wire unit_active = (tx_state != ST_IDLE) | (rx_state != ST_IDLE);
  wire [7:0] control_status_value = {mode_uart, rx_enable, spi_slave, framing_error_flag,
                                     parity_error, rx_byte, tx_byte, unit_active};

  // read selection; the clear register is write-only and reads zero
  wire [7:0] read_value =
    (addr == IDX_DATA_BUFFER) ? rx_buffer :
    (addr == IDX_BAUD_MANTISSA) ? baud_mantissa :
    (addr == IDX_BAUD_EXPONENT) ? {3'h0, baud_exponent} :
    (addr == IDX_FRAME_CONFIG) ? {5'h00, frame_config} :
    (addr == IDX_CONTROL_STATUS) ? control_status_value :
    (addr == IDX_IRQ_STATUS) ? {4'h0, irq_status} :
    (addr == IDX_IRQ_ENABLE) ? {4'h0, irq_enable} :
    UNMAPPED_VALUE;

  // handshake flops; waitrequest idles high so no request is missed
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
      readdata <= 8'h00;
    end else if (ce) begin
      waitrequest <= ~(bus_active & waitrequest);
      if (bus_req.read & waitrequest) readdata <= read_value;
    end
  end

  // ==========================================================================
  // transmit engine decode: uart frames, spi master and spi slave
  wire tx_is_spi = tx_state == ST_SPI;
  wire tx_is_slave = tx_is_spi & spi_slave;
  wire slave_rise = spi_s.sck & ~sck_prev;
  wire slave_fall = ~spi_s.sck & sck_prev;
  wire slave_load = ~mode_uart & spi_slave & ~spi_s.ss_b;
  wire tx_load = (tx_state == ST_IDLE) & (slave_load | (tx_pending & (mode_uart | ~spi_slave)));
  wire tx_abort = tx_is_slave & spi_s.ss_b;
  wire tx_sub_step = tick & (tx_state != ST_IDLE) & ~tx_is_slave;
  wire tx_bit_end = tx_sub_step & (tx_sub == SUB_LAST);
  wire spi_sample_now = tx_is_spi &
                        (spi_slave ? slave_rise : tx_sub_step & (tx_sub == SUB_SAMPLE));
  wire spi_sample_in = spi_slave ? spi_s.mosi : spi_s.miso;
  wire tx_shift_now = ((tx_state == ST_DATA) & tx_bit_end) |
                      (tx_is_spi & (spi_slave ? slave_fall : tx_bit_end));
  wire tx_advance = tx_bit_end | (tx_is_slave & slave_fall);
  wire spi_done = tx_is_spi & tx_shift_now & (tx_bit == LAST_BIT);
  wire tx_uart_done = tx_bit_end & ~tx_is_spi & (next_tx_state == ST_IDLE);
  wire tx_line = (tx_state == ST_START) ? 1'b0 :
                 (tx_state == ST_DATA) ? tx_shift[0] :
                 (tx_state == ST_PARITY) ? tx_parity : 1'b1;

  assign next_tx_state = frame_next(tx_state, tx_bit, frame_config);

  // transmit engine; lsb first, parity folded in while shifting
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= ST_IDLE;
      tx_sub <= 3'h0;
      tx_bit <= 3'h0;
      tx_shift <= RST_DATA_BUFFER;
      tx_parity <= 1'b0;
      spi_sample <= 1'b0;
    end else if (ce) begin
      if (tx_load) begin
        tx_state <= mode_uart ? ST_START : ST_SPI;
        tx_shift <= tx_buffer;
        tx_sub <= 3'h0;
        tx_bit <= 3'h0;
        tx_parity <= frame_config[FRM_PARITY_ODD];
      end else if (tx_abort) begin
        tx_state <= ST_IDLE;
      end else begin
        if (tx_sub_step) tx_sub <= tx_sub + 3'h1;
        if (spi_sample_now) spi_sample <= spi_sample_in;
        if (tx_shift_now) begin
          tx_shift <= {spi_sample, tx_shift[7:1]};
          tx_parity <= tx_parity ^ tx_shift[0];
          tx_bit <= tx_bit + 3'h1;
        end
        if (tx_advance) tx_state <= next_tx_state;
      end
    end
  end

  // ==========================================================================
  // receive engine decode; a high line at mid start is a glitch
  wire rx_start = (rx_state == ST_IDLE) & mode_uart & rx_enable & ~rxd_s;
  wire rx_sample_now = (rx_state != ST_IDLE) & tick & (rx_sub == SUB_SAMPLE);
  wire rx_stop1 = rx_sample_now & (rx_state == ST_STOP1);
  wire rx_stop2 = rx_sample_now & (rx_state == ST_STOP2);

  assign next_rx_state = ((rx_state == ST_START) & rxd_s) ? ST_IDLE :
                         frame_next(rx_state, rx_bit, frame_config);

  // receive engine; states advance at each mid-bit sample
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= ST_IDLE;
      rx_sub <= 3'h0;
      rx_bit <= 3'h0;
      rx_shift <= RST_DATA_BUFFER;
      rx_parity <= 1'b0;
    end else if (ce) begin
      if (rx_start) begin
        rx_state <= ST_START;
        rx_sub <= 3'h0;
        rx_bit <= 3'h0;
        rx_parity <= frame_config[FRM_PARITY_ODD];
      end else if (~mode_uart | ~rx_enable) begin
        rx_state <= ST_IDLE;
      end else begin
        if ((rx_state != ST_IDLE) & tick) rx_sub <= rx_sub + 3'h1;
        if (rx_sample_now) begin
          rx_state <= next_rx_state;
          if (rx_state == ST_DATA) begin
            rx_shift <= {rxd_s, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
          end
          if ((rx_state == ST_DATA) | (rx_state == ST_PARITY)) rx_parity <= rx_parity ^ rxd_s;
        end
      end
    end
  end

  // ==========================================================================
  // events: rx byte flag at first stop, tx byte flag after the last stop; second stop can only add framing
  wire rx_got = rx_stop1 | spi_done;
  wire tx_sent = tx_uart_done | spi_done;
  wire framing_set = (rx_stop1 | rx_stop2) & ~rxd_s;
  wire parity_set = rx_stop1 & frame_config[FRM_PARITY_EN] & rx_parity;
  wire [IRQ_WIDTH-1:0] irq_events = {parity_set, framing_set, tx_sent, rx_got};
  wire [IRQ_WIDTH-1:0] irq_clear_mask = wr_irq_clear ? wd[IRQ_WIDTH-1:0] : RST_IRQ;

  // configuration registers and the transmit queue flag
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buffer <= RST_DATA_BUFFER;
      baud_mantissa <= RST_BAUD_MANTISSA;
      baud_exponent <= RST_BAUD_EXPONENT;
      frame_config <= RST_FRAME_CONFIG;
      mode_uart <= 1'b0;
      rx_enable <= 1'b0;
      spi_slave <= 1'b0;
      irq_enable <= RST_IRQ;
      tx_pending <= 1'b0;
    end else if (ce) begin
      if (wr_data) tx_buffer <= wd;
      if (wr_mantissa) baud_mantissa <= wd;
      if (wr_exponent) baud_exponent <= wd[4:0];
      if (wr_frame) frame_config <= wd[2:0];
      if (wr_cs) begin
        mode_uart <= wd[CS_MODE];
        rx_enable <= wd[CS_RX_ENABLE];
        spi_slave <= wd[CS_SLAVE];
      end
      if (wr_irq_enable) irq_enable <= wd[IRQ_WIDTH-1:0];
      // a new write while queued replaces the queued byte
      tx_pending <= wr_data | (tx_pending & ~tx_load);
    end
  end

  // status flags: a hardware set wins over a software write or clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buffer <= RST_DATA_BUFFER;
      framing_error_flag <= 1'b0;
      parity_error <= 1'b0;
      rx_byte <= 1'b0;
      tx_byte <= 1'b0;
      irq_status <= RST_IRQ;
    end else if (ce) begin
      if (rx_stop1) rx_buffer <= rx_shift;
      else if (spi_done) rx_buffer <= {spi_sample, tx_shift[7:1]};
      framing_error_flag <= framing_set | (wr_cs ? wd[CS_FRAMING] : framing_error_flag);
      parity_error <= parity_set | (wr_cs ? wd[CS_PARITY] : parity_error);
      rx_byte <= rx_got | (wr_cs ? wd[CS_RX_BYTE] : rx_byte);
      // a fresh data write means the last byte is not yet out
      tx_byte <= tx_sent | (wr_cs ? wd[CS_TX_BYTE] : (tx_byte & ~wr_data));
      irq_status <= irq_events | (irq_status & ~irq_clear_mask);
    end
  end

  // ==========================================================================
  // registered pins; master sck idles low and rises at subtick four
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txd <= 1'b1;
      irq <= 1'b0;
      spi_out <= '0;
    end else if (ce) begin
      txd <= tx_line;
      irq <= |(irq_status & irq_enable);
      spi_out.sck <= tx_is_spi & ~spi_slave & tx_sub[2];
      spi_out.sck_oe <= ~mode_uart & ~spi_slave;
      spi_out.mosi <= tx_shift[0];
      spi_out.mosi_oe <= ~mode_uart & ~spi_slave;
      spi_out.miso <= tx_shift[0];
      spi_out.miso_oe <= ~mode_uart & spi_slave & ~spi_s.ss_b;
    end
  end

endmodule // usart_data_baud_status_regs

// File: sim/serial_peer.sv
// remote peer: uart sender and decoder, spi slave in mode 0, lsb first
module serial_peer #(
  parameter int BIT_CYCLES = 64
) (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd,
  input wire logic send,
  input wire logic [11:0] frame,
  input wire logic [3:0] frame_len,
  output logic [7:0] got_byte,
  output logic [7:0] got_count,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  input wire logic spi_load,
  input wire logic [7:0] spi_reply,
  output logic [7:0] spi_got
);
  logic [7:0] shreg;
  logic sck_d;
  initial rxd = 1'h1;
  initial got_count = 8'h00;

  // sender: frame bits go out lsb first, line idles high between frames
  always @(posedge mclk) begin
    if (send) begin
      for (int i = 0; i < frame_len; i++) begin
        rxd <= frame[i];
        repeat (BIT_CYCLES) @(posedge mclk);
      end
      rxd <= 1'h1;
    end
  end

  // decoder: samples mid-bit, then waits into the stop bit before rearming
  always @(negedge txd) begin
    repeat (BIT_CYCLES / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge mclk);
      got_byte[i] = txd;
    end
    repeat (BIT_CYCLES) @(posedge mclk);
    got_count = got_count + 8'h01;
  end

  // spi slave: shift out on falling sck, capture mosi on rising sck
  always @(posedge mclk) begin
    sck_d <= sck;
    if (spi_load) shreg <= spi_reply;
    else if (sck_d && !sck) shreg <= {1'h0, shreg[7:1]};
    if (!sck_d && sck) spi_got <= {mosi, spi_got[7:1]};
  end
  assign miso = shreg[0];
endmodule // serial_peer

// File: sim/testbench.sv
// self-checking bench for the dual-mode serial unit
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_unit_pkg::*;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  bus_request_type bus_req = '0;
  logic [7:0] readdata, got_byte, got_count, spi_got, q, n0;
  logic waitrequest, irq, txd, rxd, peer_miso;
  logic send = 1'h0;
  logic spi_load = 1'h0;
  logic [11:0] frame = 12'hFFF;
  logic [3:0] frame_len = 4'h0;
  logic [7:0] regs [5] = '{IDX_DATA_BUFFER, IDX_BAUD_MANTISSA, IDX_BAUD_EXPONENT,
    IDX_CONTROL_STATUS, IDX_IRQ_STATUS};
  spi_in_type spi_in;
  spi_out_type spi_out;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  // released sck pulls low, released mosi pulls high; select stays off
  assign spi_in = '{sck: spi_out.sck_oe & spi_out.sck, mosi: spi_out.mosi_oe ? spi_out.mosi : 1'h1,
    miso: spi_out.miso_oe ? spi_out.miso : peer_miso, ss_b: 1'h1};

  usart_data_baud_status_regs u_dut (.mclk(mclk), .rst_b(rst_b), .ce(1'h1), .bus_req(bus_req),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .txd(txd), .rxd(rxd),
    .spi_in(spi_in), .spi_out(spi_out));
  serial_peer #(.BIT_CYCLES(64)) u_peer (.mclk(mclk), .txd(txd), .rxd(rxd), .send(send),
    .frame(frame), .frame_len(frame_len), .got_byte(got_byte), .got_count(got_count),
    .sck(spi_in.sck), .mosi(spi_in.mosi), .miso(peer_miso), .spi_load(spi_load),
    .spi_reply(8'h5A), .spi_got(spi_got));

  // ==========================================================================
  // tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon access held until waitrequest is sampled low, then one idle edge
  task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge mclk);
    while (waitrequest !== 1'h0) @(posedge mclk);
    q = readdata;
    bus_req <= '0;
    @(posedge mclk);
  endtask
  task poll(input int b);
    acc(1'h0, IDX_CONTROL_STATUS, 8'h00);
    for (int i = 0; i < 400 && q[b] !== 1'h1; i++) acc(1'h0, IDX_CONTROL_STATUS, 8'h00);
  endtask
  // wait out the peer's previous frame first, or the send strobe is missed
  task line_frame(input logic [11:0] f, input logic [3:0] n);
    repeat (80) @(posedge mclk);
    frame <= f;
    frame_len <= n;
    send <= 1'h1;
    @(posedge mclk);
    send <= 1'h0;
  endtask

  // hang guard, well beyond the few thousand cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      acc(1'h0, regs[i], 8'h00);
      chk("reset value", q, 8'h00);
    end
    acc(1'h1, IDX_BAUD_MANTISSA, 8'hA7);
    acc(1'h0, IDX_BAUD_MANTISSA, 8'h00);
    chk("mantissa", q, 8'hA7);
    acc(1'h1, IDX_BAUD_EXPONENT, 8'h1F);
    acc(1'h0, IDX_BAUD_EXPONENT, 8'h00);
    chk("exponent", q, 8'h1F);
    acc(1'h0, 8'h33, 8'h00);
    chk("unmapped", q, 8'h00);
    // eight cycles per subtick keeps sck slow against the input synchronisers
    acc(1'h1, IDX_BAUD_MANTISSA, 8'h00);
    acc(1'h1, IDX_BAUD_EXPONENT, 8'h0E);
    // spi master exchange
    spi_load <= 1'h1;
    @(posedge mclk);
    spi_load <= 1'h0;
    acc(1'h1, IDX_CONTROL_STATUS, 8'h00);
    acc(1'h1, IDX_DATA_BUFFER, 8'h96);
    poll(CS_TX_BYTE);
    chk("spi sent", spi_got, 8'h96);
    chk("spi status", q, 8'h06);
    acc(1'h0, IDX_DATA_BUFFER, 8'h00);
    chk("spi received", q, 8'h5A);
    // status flags cleared by software, busy bit ignores writes
    acc(1'h1, IDX_CONTROL_STATUS, 8'h81);
    acc(1'h0, IDX_CONTROL_STATUS, 8'h00);
    chk("status write", q, 8'h80);
    // uart transmit
    n0 = got_count;
    acc(1'h1, IDX_DATA_BUFFER, 8'hC3);
    acc(1'h0, IDX_CONTROL_STATUS, 8'h00);
    chk("tx busy", q & 8'h03, 8'h01);
    poll(CS_TX_BYTE);
    chk("tx done", q & 8'h03, 8'h02);
    chk("tx byte", got_byte, 8'hC3);
    chk("tx count", got_count, n0 + 8'h01);
    // uart receive with interrupt, then clear
    acc(1'h1, IDX_CONTROL_STATUS, 8'hC0);
    // the spi exchange left the rx event pending, drop it before enabling
    acc(1'h1, IDX_IRQ_CLEAR, 8'h0F);
    acc(1'h1, IDX_IRQ_ENABLE, 8'h01);
    chk("irq idle", {7'h00, irq}, 8'h00);
    line_frame({3'h7, 8'h3C, 1'h0}, 4'hA);
    poll(CS_RX_BYTE);
    chk("rx flags", q & 8'h1C, 8'h04);
    acc(1'h0, IDX_DATA_BUFFER, 8'h00);
    chk("rx byte", q, 8'h3C);
    chk("irq set", {7'h00, irq}, 8'h01);
    acc(1'h1, IDX_IRQ_CLEAR, 8'h0F);
    @(posedge mclk);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    // bad single stop bit; receiver is switched off after to drop any false start
    acc(1'h1, IDX_CONTROL_STATUS, 8'hC0);
    line_frame({3'h6, 8'h55, 1'h0}, 4'hA);
    poll(CS_RX_BYTE);
    chk("framing", q & 8'h1C, 8'h14);
    acc(1'h1, IDX_CONTROL_STATUS, 8'h80);
    // even parity with a wrong parity bit
    acc(1'h1, IDX_FRAME_CONFIG, 8'h01);
    acc(1'h1, IDX_CONTROL_STATUS, 8'hC0);
    line_frame({3'h7, 8'h55, 1'h0}, 4'hB);
    poll(CS_RX_BYTE);
    chk("parity", q & 8'h1C, 8'h0C);
    acc(1'h1, IDX_CONTROL_STATUS, 8'h80);
    // two stop bits, second low: framing follows one bit later
    acc(1'h1, IDX_FRAME_CONFIG, 8'h04);
    acc(1'h1, IDX_CONTROL_STATUS, 8'hC0);
    line_frame({3'h5, 8'hA5, 1'h0}, 4'hB);
    poll(CS_RX_BYTE);
    chk("first stop", q & 8'h1C, 8'h04);
    repeat (80) @(posedge mclk);
    acc(1'h0, IDX_CONTROL_STATUS, 8'h00);
    chk("second stop", q & 8'h1C, 8'h14);
    report_and_stop;
  end
endmodule // testbench

// File: sim/usart_regs_monitor.sv
// concurrent checks on the serial unit register bus and pin enables
module usart_regs_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire serial_unit_pkg::bus_request_type bus_req,
  input wire logic [7:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic txd,
  input wire logic rxd,
  input wire serial_unit_pkg::spi_in_type spi_in,
  input wire serial_unit_pkg::spi_out_type spi_out
);
  import serial_unit_pkg::*;
  // ==========================================================================
  // shadow of software-owned fields; hardware never alters them
  logic mode_sh, rxen_sh, slave_sh;
  logic [7:0] mant_sh;
  logic [3:0] en_sh;
  logic [1:0] settle;
  wire logic acc_done = !waitrequest && (bus_req.read || bus_req.write);
  wire logic wr_done = acc_done && bus_req.write;
  wire logic rd_done = acc_done && bus_req.read;
  // irq clear is write-only, so it reads like a hole
  wire logic hole = !(bus_req.address inside {IDX_DATA_BUFFER, IDX_BAUD_MANTISSA,
    IDX_FRAME_CONFIG, IDX_BAUD_EXPONENT, IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_CONTROL_STATUS});

  // settle counts edges since the last control write, pins lag by a register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {mode_sh, rxen_sh, slave_sh} <= 3'h0;
      mant_sh <= 8'h00;
      en_sh <= 4'h0;
      settle <= 2'h0;
    end else begin
      if (wr_done && bus_req.address == IDX_CONTROL_STATUS) begin
        {mode_sh, rxen_sh, slave_sh} <= bus_req.writedata[7:5];
        settle <= 2'h0;
      end else if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
      if (wr_done && bus_req.address == IDX_BAUD_MANTISSA) mant_sh <= bus_req.writedata;
      if (wr_done && bus_req.address == IDX_IRQ_ENABLE) en_sh <= bus_req.writedata[3:0];
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_wait_one_cycle: assert property ((bus_req.read || bus_req.write) && waitrequest && ce
    |=> !waitrequest) else $error("request not answered after one wait cycle");
  a_wait_low_pulse: assert property (!waitrequest && ce |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_read_hole_zero: assert property (rd_done && hole |-> readdata == UNMAPPED_VALUE)
    else $error("unmapped read returned nonzero");
  a_ctrl_field_read: assert property (rd_done && bus_req.address == IDX_CONTROL_STATUS
    |-> readdata[7:5] == {mode_sh, rxen_sh, slave_sh}) else $error("control fields wrong");
  a_mantissa_read: assert property (rd_done && bus_req.address == IDX_BAUD_MANTISSA
    |-> readdata == mant_sh) else $error("mantissa readback wrong");
  a_master_pin_drive: assert property (settle == 2'h3 |-> spi_out.sck_oe == (!mode_sh &&
    !slave_sh) && spi_out.mosi_oe == spi_out.sck_oe) else $error("master enables wrong");
  a_miso_held_off: assert property (settle == 2'h3 && (mode_sh || !slave_sh)
    |-> !spi_out.miso_oe) else $error("miso driven outside slave mode");
  a_uart_sck_quiet: assert property (settle == 2'h3 && mode_sh |-> !spi_out.sck)
    else $error("sck toggles in uart mode");
  a_spi_txd_idle: assert property (settle == 2'h3 && !mode_sh |-> txd)
    else $error("txd left idle level in spi mode");
  a_irq_masked: assert property (en_sh == 4'h0 && $past(en_sh) == 4'h0 |-> !irq)
    else $error("irq raised while all sources masked");
endmodule // usart_regs_monitor

bind usart_data_baud_status_regs usart_regs_monitor u_monitor (.mclk(mclk), .rst_b(rst_b),
  .ce(ce), .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
  .txd(txd), .rxd(rxd), .spi_in(spi_in), .spi_out(spi_out));
